// >>> common/sysctl_gate_pkg.sv
// Purpose: shared constants for the clock gating and soft reset block
// Assumes: 32-bit APB data, 12-bit byte address, one aligned word per register
// Notes:   register masks keep reserved bits at zero

package sysctl_gate_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] SOFT_RESET_CTL_0_OFF = 12'h040; // soft reset control 0
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFF = 12'h060; // auto gating enable
  localparam logic [11:0] CAPABILITIES_1_OFF = 12'h010; // read-only capabilities
  localparam logic [11:0] RUN_GATE_SET_2_OFF = 12'h108; // run gating set
  localparam logic [11:0] SLEEP_GATE_SET_2_OFF = 12'h118; // sleep gating set
  localparam logic [11:0] DEEP_SLEEP_GATE_SET_2_OFF = 12'h128; // deep-sleep gating set

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ETH_PHY_GATE_POS = 30; // ethernet phy gate
  localparam int ETH_MAC_GATE_POS = 28; // ethernet mac gate
  localparam int PORT_A_GATE_POS = 0; // ports a..g sit at 0..6
  localparam int ADC_SOFT_RESET_POS = 16; // converter soft reset
  localparam int WATCHDOG_SOFT_RESET_POS = 3; // watchdog soft reset
  localparam int AUTO_SLEEP_GATING_POS = 0; // auto gating bit
  localparam int NUM_UNITS = 9; // gated units
  // unit index to gate bit: ports a..g, then mac, then phy
  localparam int UNIT_BIT [NUM_UNITS] = '{0, 1, 2, 3, 4, 5, 6, 28, 30};

  // ----------------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] GATE_SET_2_RW = 32'h5000007F; // phy, mac, ports
  localparam logic [31:0] SOFT_RESET_CTL_0_RW = 32'h00010008; // converter, watchdog
  localparam logic [31:0] GATE_SET_2_RESET = 32'h00000000; // all units unclocked
  localparam logic [31:0] SOFT_RESET_CTL_0_RESET = 32'h00000000; // no unit held
  localparam logic AUTO_SLEEP_GATING_RESET = 1'b0; // sleep and deep-sleep sets off

  // ----------------------------------------------------------------------
  // registered state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] run_gate; // run gating set
    logic [31:0] sleep_gate; // sleep gating set
    logic [31:0] deep_gate; // deep-sleep gating set
    logic [31:0] soft_rst; // soft reset control 0
    logic auto_sleep_gating; // auto sleep gating enable
    logic [NUM_UNITS-1:0] clk_en; // gate in force per unit
    logic unit_fault; // access to unclocked unit
    logic pready; // apb answer
    logic pslverr; // apb error
    logic [31:0] prdata; // apb read data
  } gate_state_s;

endpackage : sysctl_gate_pkg

// >>> core/deep_sleep_gating.sv
// Purpose: clock gating sets, soft reset control and unclocked-access faults
// Assumes: APB master on pclk; power mode and unit select come from pclk logic
// Notes:   all outputs are flip-flops; ce low freezes the whole block

`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - set deep gate bit clocks its unit
// RQ2 - access to unclocked unit gives bus fault
// RQ3 - all gating bits reset to zero
// RQ4 - run, sleep, deep sets follow power mode
// RQ5 - sleep sets need auto gating bit set
// RQ6 - bit 30 phy, bit 28 mac gates
// RQ7 - bits 6..0 gate ports g..a
// RQ8 - reserved bits read zero, software preserves
// RQ9 - capability bits mask soft reset writes
// RQ10 - bit 16 resets the converter
// RQ11 - bit 3 resets the watchdog
// RQ12 - unit held in reset while bit set
module deep_sleep_gating
  import sysctl_gate_pkg::*;
#(
  parameter logic [31:0] CAPS_1 = 32'h00010008 // units present, default all
) (
  input wire logic pclk, // system clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sleeping, // core in sleep
  input wire logic deep_sleeping, // core in deep sleep
  input wire logic [NUM_UNITS-1:0] unit_sel, // access aimed at unit
  output logic [NUM_UNITS-1:0] unit_clk_en, // clock enable per unit
  output logic unit_fault, // bus fault for access
  output logic adc_soft_reset, // converter held in reset
  output logic watchdog_soft_reset // watchdog held in reset
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  // capability bits outside the soft reset field have no unit to reset
  if ((CAPS_1 & ~SOFT_RESET_CTL_0_RW) != 32'h00000000) begin : g_bad_caps
    $error("capability mask names bits that have no unit");
  end

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  gate_state_s st; // registered state
  gate_state_s next_st; // next state
  logic [31:0] soft_rst_wmask; // writable soft reset bits
  logic [NUM_UNITS-1:0] run_units; // run set per unit
  logic [NUM_UNITS-1:0] sleep_units; // sleep set per unit
  logic [NUM_UNITS-1:0] deep_units; // deep set per unit
  logic [NUM_UNITS-1:0] active_units; // set in force this cycle
  logic apb_setup; // setup phase seen
  logic apb_write; // write committed this edge

  // only present units may have their reset bit changed
  assign soft_rst_wmask = SOFT_RESET_CTL_0_RW & CAPS_1; // see RQ9

  // the write lands at the edge where the master samples pready
  assign apb_setup = psel && !penable && !st.pready;
  assign apb_write = psel && penable && st.pready && pwrite;

  // ----------------------------------------------------------------------
  // per-unit gate extraction
  // ----------------------------------------------------------------------
  // pick each unit's gate bit from the three 32-bit sets
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    assign run_units[u] = st.run_gate[UNIT_BIT[u]]; // see RQ6
    assign sleep_units[u] = st.sleep_gate[UNIT_BIT[u]]; // see RQ7
    assign deep_units[u] = st.deep_gate[UNIT_BIT[u]]; // see RQ1
  end

  // ----------------------------------------------------------------------
  // power mode selection
  // ----------------------------------------------------------------------
  // sleep sets only apply with auto gating; otherwise run set rules
  always_comb begin
    if (st.auto_sleep_gating && deep_sleeping) begin
      active_units = deep_units; // see RQ4
    end else if (st.auto_sleep_gating && sleeping) begin
      active_units = sleep_units; // see RQ5
    end else begin
      active_units = run_units; // run mode or auto gating off
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // gate in force, one register stage to the unit
    next_st.clk_en = active_units; // see RQ1
    // any access to a unit without clock faults next cycle
    next_st.unit_fault = |(unit_sel & ~st.clk_en); // see RQ2
    // answer lasts one access-phase cycle
    next_st.pready = apb_setup;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h00000000;
    // read data and error prepared during setup
    if (apb_setup) begin
      if (paddr == DEEP_SLEEP_GATE_SET_2_OFF) begin
        next_st.prdata = st.deep_gate; // see RQ8
      end else if (paddr == SLEEP_GATE_SET_2_OFF) begin
        next_st.prdata = st.sleep_gate;
      end else if (paddr == RUN_GATE_SET_2_OFF) begin
        next_st.prdata = st.run_gate;
      end else if (paddr == SOFT_RESET_CTL_0_OFF) begin
        next_st.prdata = st.soft_rst; // see RQ8
      end else if (paddr == RUN_CLOCK_CONFIG_OFF) begin
        next_st.prdata[AUTO_SLEEP_GATING_POS] = st.auto_sleep_gating;
      end else if (paddr == CAPABILITIES_1_OFF) begin
        next_st.prdata = CAPS_1; // read only
      end else begin
        next_st.pslverr = 1'b1; // unmapped address
      end
    end
    // register writes, reserved bits forced to zero
    if (apb_write) begin
      if (paddr == DEEP_SLEEP_GATE_SET_2_OFF) begin
        next_st.deep_gate = pwdata & GATE_SET_2_RW; // see RQ6
      end else if (paddr == SLEEP_GATE_SET_2_OFF) begin
        next_st.sleep_gate = pwdata & GATE_SET_2_RW; // see RQ7
      end else if (paddr == RUN_GATE_SET_2_OFF) begin
        next_st.run_gate = pwdata & GATE_SET_2_RW; // see RQ4
      end else if (paddr == SOFT_RESET_CTL_0_OFF) begin
        // absent units keep their old bit
        next_st.soft_rst = (st.soft_rst & ~soft_rst_wmask)
          | (pwdata & soft_rst_wmask); // see RQ9
      end else if (paddr == RUN_CLOCK_CONFIG_OFF) begin
        next_st.auto_sleep_gating = pwdata[AUTO_SLEEP_GATING_POS]; // see RQ5
      end else begin
        next_st.auto_sleep_gating = st.auto_sleep_gating; // read-only or unmapped, nothing stored
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.run_gate <= GATE_SET_2_RESET; // see RQ3
      st.sleep_gate <= GATE_SET_2_RESET; // see RQ3
      st.deep_gate <= GATE_SET_2_RESET; // see RQ3
      st.soft_rst <= SOFT_RESET_CTL_0_RESET;
      st.auto_sleep_gating <= AUTO_SLEEP_GATING_RESET;
      st.clk_en <= '0; // see RQ3
      st.unit_fault <= 1'b0;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= 32'h00000000;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign unit_clk_en = st.clk_en;
  assign unit_fault = st.unit_fault;
  // unit stays in reset while its bit holds one
  assign adc_soft_reset = st.soft_rst[ADC_SOFT_RESET_POS]; // see RQ10, RQ12
  assign watchdog_soft_reset = st.soft_rst[WATCHDOG_SOFT_RESET_POS]; // see RQ11

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // deep-sleep set reaches the units one cycle later
  chk_deep_gate_follow: assert property ( // see RQ1
    @(posedge pclk) disable iff (!presetn)
    ce && st.auto_sleep_gating && deep_sleeping |=> unit_clk_en == $past(deep_units))
    else $error("deep-sleep gate not applied");

  // access to a gated unit faults on the next cycle
  chk_unclocked_fault: assert property ( // see RQ2
    @(posedge pclk) disable iff (!presetn)
    ce && |(unit_sel & ~unit_clk_en) |=> unit_fault)
    else $error("no fault on access to unclocked unit");

  // clocked unit accesses answer without fault
  chk_clocked_no_fault: assert property ( // see RQ2
    @(posedge pclk) disable iff (!presetn)
    ce && unit_sel != '0 && (unit_sel & ~unit_clk_en) == '0 |=> !unit_fault)
    else $error("fault on access to clocked unit");

  // everything unclocked right after reset release
  chk_reset_unclocked: assert property ( // see RQ3
    @(posedge pclk) $rose(presetn) |-> unit_clk_en == '0 && st.deep_gate == '0)
    else $error("gating not zero after reset");

  // sleep set in force while sleeping, not deep sleeping, with auto gating
  chk_sleep_set: assert property ( // see RQ4
    @(posedge pclk) disable iff (!presetn)
    ce && st.auto_sleep_gating && sleeping && !deep_sleeping |=> unit_clk_en == $past(sleep_units))
    else $error("sleep gate set not applied");

  // without auto gating only the run set counts
  chk_acg_off_run: assert property ( // see RQ5
    @(posedge pclk) disable iff (!presetn)
    ce && !st.auto_sleep_gating |=> unit_clk_en == $past(run_units))
    else $error("run set not used with auto gating off");

  // write to deep set keeps phy, mac and port bits only
  chk_deep_write: assert property ( // see RQ6
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == DEEP_SLEEP_GATE_SET_2_OFF
    |=> st.deep_gate == ($past(pwdata) & GATE_SET_2_RW))
    else $error("deep gate write wrong");

  // unit order on the pins: ports a..g, then mac, then phy
  chk_port_map: assert property ( // see RQ7
    @(posedge pclk) disable iff (!presetn)
    ce && st.auto_sleep_gating && deep_sleeping |=> unit_clk_en[6:0] == $past(st.deep_gate[6:0])
      && unit_clk_en[7] == $past(st.deep_gate[ETH_MAC_GATE_POS])
      && unit_clk_en[8] == $past(st.deep_gate[ETH_PHY_GATE_POS]))
    else $error("port gate mapping wrong");

  // reserved bits of both registers stay zero
  chk_reserved_zero: assert property ( // see RQ8
    @(posedge pclk) disable iff (!presetn)
    (st.deep_gate & ~GATE_SET_2_RW) == '0 && (st.soft_rst & ~SOFT_RESET_CTL_0_RW) == '0)
    else $error("reserved bit set");

  // absent units never get a reset bit
  chk_caps_mask: assert property ( // see RQ9
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == SOFT_RESET_CTL_0_OFF
    |=> (st.soft_rst & ~CAPS_1) == $past(st.soft_rst & ~CAPS_1))
    else $error("masked soft reset bit changed");

  // converter reset follows the written bit
  chk_adc_write: assert property ( // see RQ10
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == SOFT_RESET_CTL_0_OFF
    |=> adc_soft_reset == ($past(pwdata[ADC_SOFT_RESET_POS]) & CAPS_1[ADC_SOFT_RESET_POS]))
    else $error("converter reset not written");

  // watchdog reset holds until software writes again
  chk_wdt_hold: assert property ( // see RQ11
    @(posedge pclk) disable iff (!presetn)
    !(ce && apb_write && paddr == SOFT_RESET_CTL_0_OFF) |=> $stable(watchdog_soft_reset))
    else $error("watchdog reset changed without write");

  // held reset releases only on a write clearing it
  chk_release_write: assert property ( // see RQ12
    @(posedge pclk) disable iff (!presetn)
    $fell(adc_soft_reset) |-> $past(apb_write && paddr == SOFT_RESET_CTL_0_OFF))
    else $error("converter released without write");

  // read answer comes one cycle after setup
  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && apb_setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // read of the deep set returns the stored bits
  chk_deep_read: assert property ( // see RQ8
    @(posedge pclk) disable iff (!presetn)
    ce && apb_setup && paddr == DEEP_SLEEP_GATE_SET_2_OFF |=> prdata == $past(st.deep_gate))
    else $error("deep gate read wrong");

  // read of the soft reset register returns the stored bits
  chk_soft_read: assert property ( // see RQ8
    @(posedge pclk) disable iff (!presetn)
    ce && apb_setup && paddr == SOFT_RESET_CTL_0_OFF |=> prdata == $past(st.soft_rst))
    else $error("soft reset read wrong");

  // reserved bits of the run and sleep sets stay zero
  chk_reserved_sets: assert property ( // see RQ8
    @(posedge pclk) disable iff (!presetn)
    (st.run_gate & ~GATE_SET_2_RW) == '0 && (st.sleep_gate & ~GATE_SET_2_RW) == '0)
    else $error("reserved gate bit set");

  // run set write keeps gate bits only
  chk_run_write: assert property ( // see RQ4
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == RUN_GATE_SET_2_OFF
    |=> st.run_gate == ($past(pwdata) & GATE_SET_2_RW))
    else $error("run gate write wrong");

  // sleep set write keeps gate bits only
  chk_sleep_write: assert property ( // see RQ7
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == SLEEP_GATE_SET_2_OFF
    |=> st.sleep_gate == ($past(pwdata) & GATE_SET_2_RW))
    else $error("sleep gate write wrong");

  // auto gating bit follows its write
  chk_acg_write: assert property ( // see RQ5
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == RUN_CLOCK_CONFIG_OFF
    |=> st.auto_sleep_gating == $past(pwdata[AUTO_SLEEP_GATING_POS]))
    else $error("auto gating bit not written");

  // watchdog reset follows the written bit where the unit is present
  chk_wdt_write: assert property ( // see RQ11
    @(posedge pclk) disable iff (!presetn)
    ce && apb_write && paddr == SOFT_RESET_CTL_0_OFF
    |=> watchdog_soft_reset == ($past(pwdata[WATCHDOG_SOFT_RESET_POS])
      & CAPS_1[WATCHDOG_SOFT_RESET_POS]))
    else $error("watchdog reset not written");

  // converter reset holds until software writes again
  chk_adc_hold: assert property ( // see RQ12
    @(posedge pclk) disable iff (!presetn)
    !(ce && apb_write && paddr == SOFT_RESET_CTL_0_OFF) |=> $stable(adc_soft_reset))
    else $error("converter reset changed without write");

  // no unit selected, no fault on the next cycle
  chk_idle_no_fault: assert property ( // see RQ2
    @(posedge pclk) disable iff (!presetn)
    ce && unit_sel == '0 |=> !unit_fault)
    else $error("fault without unit access");

  // error only comes together with ready and zero data
  chk_err_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == 32'h00000000)
    else $error("error response malformed");

  // between answers the read bus stays quiet
  chk_idle_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> !pslverr && prdata == 32'h00000000)
    else $error("read bus not quiet between answers");

  // clock enable low freezes every register of the block
  chk_ce_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(st))
    else $error("state moved while clock enable low");

endmodule : deep_sleep_gating

`default_nettype wire

// >>> testbench/deep_sleep_gating_tb.sv
// Purpose: self-checking bench for the gating sets and soft reset block
// Assumes: apb master on pclk, the slave answers without wait states
// Notes:   expectations come from package masks, bit positions and the bench's own constants

`timescale 1ns/1ps
`default_nettype none

module deep_sleep_gating_tb;
  import sysctl_gate_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [31:0] CAPS = 32'h00010008; // both reset targets present
  localparam logic [11:0] UNMAPPED_OFF = 12'h7F0; // no register decoded here
  logic pclk = 1'b0; // system clock
  logic presetn = 1'b0; // held low at start
  logic ce = 1'b1; // block running
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h00000000; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready, pslverr; // apb answer
  logic sleeping = 1'b0, deep_sleeping = 1'b0; // power mode
  logic [NUM_UNITS-1:0] unit_sel = 9'h000; // access aimed at unit
  logic [NUM_UNITS-1:0] unit_clk_en; // gate in force
  logic unit_fault, adc_soft_reset, watchdog_soft_reset; // unit side outputs
  logic [31:0] rd; // last read data
  logic err; // last error response
  int num_errors = 0; // mismatches
  int checks_done = 0; // comparisons
  logic [11:0] set_off [3] = '{RUN_GATE_SET_2_OFF, SLEEP_GATE_SET_2_OFF,
                               DEEP_SLEEP_GATE_SET_2_OFF}; // run, sleep, deep
  logic [31:0] set_val [3] = '{32'h00000005, 32'h10000002, 32'h40000040}; // distinct
  deep_sleep_gating #(.CAPS_1(CAPS)) deep_sleep_gating_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleeping(sleeping),
    .deep_sleeping(deep_sleeping), .unit_sel(unit_sel), .unit_clk_en(unit_clk_en),
    .unit_fault(unit_fault), .adc_soft_reset(adc_soft_reset),
    .watchdog_soft_reset(watchdog_soft_reset));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // clock, 50 ns period
  initial begin
    forever #25 pclk = ~pclk;
  end
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge; idle edge afterwards
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // values read here are those sampled at this edge
    // wait states end only with pready; the watchdog bounds a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // gate bits of a set mapped to unit order
  function automatic logic [NUM_UNITS-1:0] units_of(input logic [31:0] set);
    for (int i = 0; i < NUM_UNITS; i++) units_of[i] = set[UNIT_BIT[i]];
  endfunction
  // apply a power mode and compare the gate in force
  task automatic mode(input logic slp, input logic dsl, input logic [31:0] set);
    sleeping <= slp;
    deep_sleeping <= dsl;
    repeat (3) @(posedge pclk);
    check(32'(unit_clk_en), 32'(units_of(set)));
  endtask
  // aim one access at a unit, fault expected only when unclocked
  task automatic probe(input int u);
    logic [NUM_UNITS-1:0] exp_on;
    exp_on = units_of(set_val[2]);
    unit_sel <= 9'h001 << u;
    @(posedge pclk);
    #1 check(32'(unit_fault), 32'(!exp_on[u]));
    @(posedge pclk);
    unit_sel <= 9'h000;
    @(posedge pclk);
  endtask
  // verdict, reached from the sequence or the watchdog
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  // watchdog: the tests need well under 1000 cycles
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DEEP_SLEEP_GATE_SET_2_OFF, 32'h00000000);
    check(rd, GATE_SET_2_RESET);
    apb(1'b0, SOFT_RESET_CTL_0_OFF, 32'h00000000);
    check(rd, SOFT_RESET_CTL_0_RESET);
    check(32'(unit_clk_en), 32'h00000000);
    $display("test reset values done");
    // all ones into every set, only gate bits stick
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, set_off[s], 32'hFFFFFFFF);
      apb(1'b0, set_off[s], 32'h00000000);
      check(rd, GATE_SET_2_RW);
    end
    $display("test gate fields done");
    // soft reset: masked write, bit positions, hold and release
    apb(1'b1, SOFT_RESET_CTL_0_OFF, 32'hFFFFFFFF);
    apb(1'b0, SOFT_RESET_CTL_0_OFF, 32'h00000000);
    check(rd, SOFT_RESET_CTL_0_RW & CAPS);
    check(32'(adc_soft_reset), 32'h00000001);
    check(32'(watchdog_soft_reset), 32'h00000001);
    apb(1'b1, SOFT_RESET_CTL_0_OFF, 32'h00000008);
    check(32'(adc_soft_reset), 32'h00000000);
    check(32'(watchdog_soft_reset), 32'h00000001);
    apb(1'b1, SOFT_RESET_CTL_0_OFF, 32'h00000000);
    check(32'(watchdog_soft_reset), 32'h00000000);
    $display("test soft reset done");
    // unmapped place refused, capabilities read-only
    apb(1'b1, UNMAPPED_OFF, 32'hFFFFFFFF);
    check(32'(err), 32'h00000001);
    apb(1'b0, UNMAPPED_OFF, 32'h00000000);
    check(32'(err), 32'h00000001);
    check(rd, 32'h00000000);
    apb(1'b1, CAPABILITIES_1_OFF, 32'h00000000);
    apb(1'b0, CAPABILITIES_1_OFF, 32'h00000000);
    check(32'(err), 32'h00000000);
    check(rd, CAPS);
    $display("test refusals done");
    // distinct pattern per set, modes without and with auto gating
    for (int s = 0; s < 3; s++) apb(1'b1, set_off[s], set_val[s]);
    mode(1'b0, 1'b0, set_val[0]);
    mode(1'b1, 1'b0, set_val[0]);
    mode(1'b0, 1'b1, set_val[0]);
    apb(1'b1, RUN_CLOCK_CONFIG_OFF, 32'h00000001 << AUTO_SLEEP_GATING_POS);
    apb(1'b0, RUN_CLOCK_CONFIG_OFF, 32'h00000000);
    check(rd, 32'h00000001 << AUTO_SLEEP_GATING_POS);
    mode(1'b0, 1'b0, set_val[0]);
    mode(1'b1, 1'b0, set_val[1]);
    mode(1'b1, 1'b1, set_val[2]);
    mode(1'b0, 1'b1, set_val[2]);
    $display("test power modes done");
    // clock enable low: a mode change must not reach the units
    ce <= 1'b0;
    sleeping <= 1'b1;
    deep_sleeping <= 1'b0;
    repeat (3) @(posedge pclk);
    check(32'(unit_clk_en), 32'(units_of(set_val[2])));
    ce <= 1'b1;
    mode(1'b0, 1'b1, set_val[2]);
    $display("test clock enable done");
    // every unit probed in deep sleep, phy and port g clocked
    for (int u = 0; u < NUM_UNITS; u++) probe(u);
    $display("test unclocked access done");
    // reset again in mid-run: sets and gates back to zero
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SLEEP_GATE_SET_2_OFF, 32'h00000000);
    check(rd, GATE_SET_2_RESET);
    check(32'(unit_clk_en), 32'h00000000);
    $display("test second reset done");
    test_done;
  end
endmodule // deep_sleep_gating_tb

`default_nettype wire
